/* rtl/typeb_cmd_regs.svh */
// Constants of the Type B halt, attribute and select command handler.
// Assumes byte-framed receive and transmit paths on the same clock.
`ifndef TYPEB_CMD_REGS_SVH
`define TYPEB_CMD_REGS_SVH
`define CRC_B_INIT     16'hFFFF
`define CRC_B_POLY     16'h8408
`define CRC_B_RESIDUE  16'hF0B8
`define ATTR_CODE      8'h1D
`define MBL_CODE       4'h1
`define CID_NONE       4'h0
`define HALT_CODE      8'h50
`define HALT_ACK       8'h00
`define CLA_STD        8'h00
`define INS_SELECT     8'hA4
`define INS_READ       8'hB0
`define P1P2_EF        16'h020C
`define P1P2_APP       16'h0400
`define P1P2_FID       16'h000C
`define LC_APP         8'h07
`define LC_FILE        8'h02
`define LE_APP         8'h00
`define NDEF_AID       56'hD276_0000_8501_01
`define CC_FILE_ID     16'hE103
`define NDEF_FILE_ID   16'h0103
`define SW_OK          16'h9000
`define SW_ERR         16'h6A82
`define RX_DEPTH       16
`endif

/* rtl/typeb_cmd_pkg.sv */
// Types shared by the Type B command handler.
// Constants live in typeb_cmd_regs.svh.
package typeb_cmd_pkg;
    typedef enum logic [1:0] {ST_RX, ST_DECIDE, ST_TX} phase_t;
    typedef enum logic [2:0] {SEL_NONE, SEL_EF, SEL_APP, SEL_CC, SEL_NDEF} sel_t;
    typedef struct packed {
        phase_t          ph;
        logic [15:0][7:0] rb;
        logic [7:0]      rlen;
        logic [15:0]     rcrc;
        logic [1:0][7:0] rsp;
        logic [1:0]      rsp_len;
        logic [2:0]      pos;
        logic [15:0]     tcrc;
        logic            tv;
        logic [7:0]      td;
        logic            tl;
        logic            halt_pend;
        logic            halted;
        sel_t            sel;
        logic [15:0]     elementary_file_identifier;
        logic            rd_mem;
        logic            rd_host;
        logic [15:0]     rd_addr;
        logic [7:0]      rd_len;
    } state_t;
endpackage

/* rtl/crc_b_step.sv */
// One-byte step of the reflected CRC_B polynomial, LSB first.
// Purely combinational; the caller holds the running value.
`timescale 1ns/1ps
`include "typeb_cmd_regs.svh"
module crc_b_step (
    // Running value and new byte
    input  wire logic [15:0] crc_in,
    input  wire logic [7:0]  data,
    // Updated value
    output logic      [15:0] crc_out
);
    // Bitwise shift, eight steps per byte
    always_comb begin
        logic [15:0] c;
        c = crc_in ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ `CRC_B_POLY) : (c >> 1);
        end
        crc_out = c;
    end
endmodule // crc_b_step

/* rtl/typeb_halt_select_cmd.sv */
// Type B command handler: attribute answer, halt, file select, read dispatch.
// Assumes receive, transmit, identifier and tunnel inputs share REF_CLK.
`timescale 1ns/1ps
`include "typeb_cmd_regs.svh"
module typeb_halt_select_cmd
    import typeb_cmd_pkg::*;
(
    // Clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    // Received frame bytes, CRC_B included
    input  wire logic        RX_VALID,
    input  wire logic [7:0]  RX_DATA,
    input  wire logic        RX_END,
    // Tag identity and mode
    input  wire logic [31:0] PSEUDO_UNIQUE_ID,
    input  wire logic        TUNNEL_MODE,
    // Response bytes toward the modulator
    output logic             TX_VALID,
    output logic [7:0]       TX_DATA,
    output logic             TX_LAST,
    input  wire logic        TX_READY,
    // Tag state
    output logic             HALTED,
    output logic [2:0]       SEL_KIND,
    output logic [15:0]      SEL_ELEMENTARY_FILE_IDENTIFIER,
    // Read dispatch
    output logic             RD_MEM_REQ,
    output logic             RD_HOST_REQ,
    output logic [15:0]      RD_ADDR,
    output logic [7:0]       RD_LEN
);
    state_t      s_q;
    state_t      s_d;
    logic [15:0] rx_crc_nx;
    logic [15:0] tx_crc_nx;

    // CRC over received bytes and over transmitted bytes
    crc_b_step u_rx_crc (
        .crc_in  (s_q.rcrc),
        .data    (RX_DATA),
        .crc_out (rx_crc_nx)
    );
    crc_b_step u_tx_crc (
        .crc_in  (s_q.tcrc),
        .data    (s_q.td),
        .crc_out (tx_crc_nx)
    );

    // Frame decode, valid during the decide phase
    logic [7:0]  nbody;
    logic        dec;
    logic        crc_ok;
    logic        is_attr;
    logic        halt_ok;
    logic        is_halt;
    logic        cla_ok;
    logic [7:0]  ins;
    logic [15:0] p1p2;
    logic [7:0]  lc;
    logic        p_app;
    logic        p_fid;
    logic        p_ef;
    logic        len_ok;
    logic        aid_ok;
    logic [15:0] fid;
    logic        sel_good;
    logic        is_read;

    assign dec     = (s_q.ph == ST_DECIDE);
    assign nbody   = s_q.rlen - 8'h02;
    // Short frames can not carry a CRC, so they fail too
    assign crc_ok  = (s_q.rcrc == `CRC_B_RESIDUE) && (s_q.rlen >= 8'h03);
    assign is_attr = (s_q.rb[0] == `ATTR_CODE);
    assign is_halt = (s_q.rb[0] == `HALT_CODE);
    assign halt_ok = is_halt && (nbody == 8'h05) &&
                     ({s_q.rb[1], s_q.rb[2], s_q.rb[3], s_q.rb[4]} == PSEUDO_UNIQUE_ID);
    assign cla_ok  = (s_q.rb[0] == `CLA_STD);
    assign ins     = s_q.rb[1];
    assign p1p2    = {s_q.rb[2], s_q.rb[3]};
    assign lc      = s_q.rb[4];
    assign p_app   = (p1p2 == `P1P2_APP);
    assign p_fid   = (p1p2 == `P1P2_FID);
    assign p_ef    = (p1p2 == `P1P2_EF);
    // Expected-length byte only on application select, and only as 0x00
    assign len_ok  = p_app ? ((lc == `LC_APP) && ((nbody == 8'h0C) ||
                     ((nbody == 8'h0D) && (s_q.rb[12] == `LE_APP))))
                           : ((lc == `LC_FILE) && (nbody == 8'h07));
    assign aid_ok  = ({s_q.rb[5], s_q.rb[6], s_q.rb[7], s_q.rb[8], s_q.rb[9],
                       s_q.rb[10], s_q.rb[11]} == `NDEF_AID);
    assign fid     = {s_q.rb[5], s_q.rb[6]};
    assign sel_good = cla_ok && (ins == `INS_SELECT) && (p_app || p_fid || p_ef) &&
                      len_ok && (!p_app || aid_ok);
    assign is_read = cla_ok && (ins == `INS_READ) && (nbody == 8'h05);

    // Next-state logic for receive, decide and transmit
    always_comb begin
        s_d = s_q;
        s_d.rd_mem = 1'b0;
        s_d.rd_host = 1'b0;
        unique case (s_q.ph)
            ST_RX: begin
                // Bytes past the buffer still feed the CRC and the count
                if (RX_VALID) begin
                    s_d.rcrc = rx_crc_nx;
                    if (s_q.rlen < 8'd`RX_DEPTH) begin
                        s_d.rb[s_q.rlen[3:0]] = RX_DATA;
                    end
                    if (s_q.rlen != 8'hFF) begin
                        s_d.rlen = s_q.rlen + 8'h01;
                    end
                end
                if (RX_END) begin
                    s_d.ph = ST_DECIDE;
                end
            end
            ST_DECIDE: begin
                s_d.rlen = 8'h00;
                s_d.rcrc = `CRC_B_INIT;
                s_d.ph = ST_RX;
                s_d.pos = 3'd0;
                s_d.tcrc = `CRC_B_INIT;
                // A halted tag stays silent; bad frames get no answer
                if (crc_ok && !s_q.halted) begin
                    if (is_attr) begin
                        s_d.rsp[0] = {`MBL_CODE, `CID_NONE};
                        s_d.rsp_len = 2'd1;
                        s_d.ph = ST_TX;
                    end else if (is_halt) begin
                        if (halt_ok) begin
                            s_d.rsp[0] = `HALT_ACK;
                            s_d.rsp_len = 2'd1;
                            s_d.halt_pend = 1'b1;
                            s_d.ph = ST_TX;
                        end
                    end else if (is_read) begin
                        // Payload path lives elsewhere; only dispatch here
                        s_d.rd_host = TUNNEL_MODE;
                        s_d.rd_mem = !TUNNEL_MODE;
                        s_d.rd_addr = p1p2;
                        s_d.rd_len = lc;
                    end else begin
                        // Status words only, never file control information
                        s_d.rsp = sel_good ? `SW_OK : `SW_ERR;
                        s_d.rsp_len = 2'd2;
                        s_d.ph = ST_TX;
                        if (sel_good) begin
                            if (p_app) begin
                                s_d.sel = SEL_APP;
                            end else if (p_fid && fid == `CC_FILE_ID) begin
                                s_d.sel = SEL_CC;
                            end else if (p_fid && fid == `NDEF_FILE_ID) begin
                                s_d.sel = SEL_NDEF;
                            end else begin
                                // Reserved identifiers sent with P1P2_EF land here too
                                s_d.sel = SEL_EF;
                                s_d.elementary_file_identifier = fid;
                            end
                        end
                    end
                end
                if (s_d.ph == ST_TX) begin
                    s_d.tv = 1'b1;
                    s_d.td = s_d.rsp[s_d.rsp_len - 2'd1];
                end
            end
            ST_TX: begin
                // Body bytes go high first, then CRC low and high
                if (s_q.tv && TX_READY) begin
                    if (s_q.tl) begin
                        s_d.tv = 1'b0;
                        s_d.tl = 1'b0;
                        s_d.ph = ST_RX;
                        if (s_q.halt_pend) begin
                            s_d.halted = 1'b1;
                            s_d.halt_pend = 1'b0;
                        end
                    end else begin
                        s_d.pos = s_q.pos + 3'd1;
                        if (s_d.pos < {1'b0, s_q.rsp_len}) begin
                            s_d.tcrc = tx_crc_nx;
                            s_d.td = s_q.rsp[s_q.rsp_len - 2'd1 - s_d.pos[1:0]];
                        end else if (s_d.pos == {1'b0, s_q.rsp_len}) begin
                            s_d.tcrc = ~tx_crc_nx;
                            s_d.td = ~tx_crc_nx[7:0];
                        end else begin
                            s_d.td = s_q.tcrc[15:8];
                            s_d.tl = 1'b1;
                        end
                    end
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            s_q <= '0;
            s_q.ph <= ST_RX;
            s_q.rcrc <= `CRC_B_INIT;
            s_q.tcrc <= `CRC_B_INIT;
            s_q.sel <= SEL_NONE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign TX_VALID    = s_q.tv;
    assign TX_DATA     = s_q.td;
    assign TX_LAST     = s_q.tl;
    assign HALTED      = s_q.halted;
    assign SEL_KIND    = s_q.sel;
    assign SEL_ELEMENTARY_FILE_IDENTIFIER   = s_q.elementary_file_identifier;
    assign RD_MEM_REQ  = s_q.rd_mem;
    assign RD_HOST_REQ = s_q.rd_host;
    assign RD_ADDR     = s_q.rd_addr;
    assign RD_LEN      = s_q.rd_len;

    // Checks on the decide phase and its effects
    logic go;
    assign go = dec && crc_ok && !s_q.halted;

    attr_len_code_a: assert property (@(posedge REF_CLK) disable iff (RST)
        go && is_attr |=> TX_VALID && TX_DATA[7:4] == `MBL_CODE)
        else $error("attribute length code wrong");
    attr_cid_nib_a: assert property (@(posedge REF_CLK) disable iff (RST)
        go && is_attr |=> TX_DATA == 8'h10) else $error("attribute byte not 0x10");
    halt_wrong_id_a: assert property (@(posedge REF_CLK) disable iff (RST)
        go && is_halt && !halt_ok |=> !TX_VALID && $stable(HALTED))
        else $error("halt acted on foreign identifier");
    halt_ack_a: assert property (@(posedge REF_CLK) disable iff (RST)
        go && halt_ok |=> TX_VALID && TX_DATA == `HALT_ACK && !HALTED)
        else $error("halt acknowledge wrong");
    halt_enter_a: assert property (@(posedge REF_CLK) disable iff (RST)
        TX_VALID && TX_READY && TX_LAST && s_q.halt_pend |=> HALTED)
        else $error("halted state not entered");
    sel_bad_cla_a: assert property (@(posedge REF_CLK) disable iff (RST)
        go && !is_attr && !is_halt && !cla_ok |=> TX_VALID && TX_DATA == 8'(`SW_ERR >> 8))
        else $error("foreign class not refused");
    sel_cc_file_a: assert property (@(posedge REF_CLK) disable iff (RST)
        go && sel_good && p_fid && fid == `CC_FILE_ID |=> SEL_KIND == SEL_CC)
        else $error("capability file not selected");
    sel_ef_any_a: assert property (@(posedge REF_CLK) disable iff (RST)
        go && sel_good && p_ef |=> SEL_KIND == SEL_EF && SEL_ELEMENTARY_FILE_IDENTIFIER == $past(fid))
        else $error("elementary file select lost");
    read_route_a: assert property (@(posedge REF_CLK) disable iff (RST)
        go && is_read && !is_attr && !is_halt |=> RD_HOST_REQ == $past(TUNNEL_MODE)
        && RD_MEM_REQ != $past(TUNNEL_MODE)) else $error("read routed wrongly");
    bad_crc_quiet_a: assert property (@(posedge REF_CLK) disable iff (RST)
        dec && !crc_ok |=> !TX_VALID [*2]) else $error("answer to bad frame");
endmodule // typeb_halt_select_cmd

/* tb/typeb_reader_model.sv */
// Reader model: frames commands with CRC_B and collects the tag's answers.
// Assumes the tag answers on TX_* with a valid/ready handshake on REF_CLK.
`timescale 1ns/1ps
`include "typeb_cmd_regs.svh"
module typeb_reader_model (
    // Clock
    input  wire logic       REF_CLK,
    // Command bytes toward the tag
    output logic            RX_VALID,
    output logic [7:0]      RX_DATA,
    output logic            RX_END,
    // Response bytes from the tag
    input  wire logic       TX_VALID,
    input  wire logic [7:0] TX_DATA,
    input  wire logic       TX_LAST,
    output logic            TX_READY
);
    logic [7:0] rsp [0:7];
    int         rn = 0;
    logic       slow = 1'b0;
    logic       done = 1'b0;

    // Idle lines at time zero
    initial begin
        RX_VALID = 1'b0;
        RX_DATA  = 8'h00;
        RX_END   = 1'b0;
        TX_READY = 1'b0;
    end

    // Reflected CRC_B, complemented; worked out here, apart from the design
    function automatic logic [15:0] crc_b(input logic [7:0] f [16], input int n);
        logic [15:0] c;
        c = `CRC_B_INIT;
        for (int i = 0; i < n; i++) begin
            c = c ^ {8'h00, f[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ `CRC_B_POLY : c >> 1;
        end
        return ~c;
    endfunction

    // Sink; a slow reader toggles ready, so bytes must stand until taken
    always @(posedge REF_CLK) begin
        TX_READY <= slow ? ~TX_READY : 1'b1;
        if (TX_VALID === 1'b1 && TX_READY && rn < 8) begin
            rsp[rn] = TX_DATA;
            rn++;
            done = TX_LAST;
        end
    end

    // One frame: body, CRC_B low then high; bad flips a CRC bit on purpose
    task automatic xfer(input logic [7:0] f [16], input int n, input bit bad);
        logic [15:0] c;
        c = crc_b(f, n) ^ {15'h0000, bad};
        f[n] = c[7:0];
        f[n+1] = c[15:8];
        rn = 0;
        done = 1'b0;
        for (int i = 0; i < n + 2; i++) begin
            @(posedge REF_CLK);
            RX_VALID <= 1'b1;
            RX_DATA  <= f[i];
            RX_END   <= (i == n + 1);
        end
        @(posedge REF_CLK);
        RX_VALID <= 1'b0;
        RX_END   <= 1'b0;
        RX_DATA  <= ~f[n+1]; // Stale byte must not look valid
        for (int i = 0; i < 40 && !done; i++) @(posedge REF_CLK);
        repeat (2) @(posedge REF_CLK);
        #1;
    endtask
endmodule // typeb_reader_model

/* tb/typeb_halt_select_cmd_tb_top.sv */
// Testbench of the Type B command handler: attribute, halt, select, read.
// Assumes the reader model drives all frame inputs; identifier is fixed.
`timescale 1ns/1ps
module typeb_halt_select_cmd_tb_top;
    import typeb_cmd_pkg::*;
    logic        REF_CLK, RST, RX_VALID, RX_END, TX_VALID, TX_LAST, TX_READY;
    logic        HALTED, TUNNEL_MODE, RD_MEM_REQ, RD_HOST_REQ;
    logic [7:0]  RX_DATA, TX_DATA, RD_LEN;
    logic [15:0] SEL_ELEMENTARY_FILE_IDENTIFIER, RD_ADDR;
    logic [31:0] PSEUDO_UNIQUE_ID;
    logic [2:0]  SEL_KIND;
    logic [7:0]  f [16];
    int          error_cnt = 0, num_checks = 0, mem_n = 0, host_n = 0;

    typeb_halt_select_cmd typeb_halt_select_cmd_i (.REF_CLK(REF_CLK), .RST(RST),
        .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .RX_END(RX_END),
        .PSEUDO_UNIQUE_ID(PSEUDO_UNIQUE_ID), .TUNNEL_MODE(TUNNEL_MODE),
        .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_LAST(TX_LAST), .TX_READY(TX_READY),
        .HALTED(HALTED), .SEL_KIND(SEL_KIND), .SEL_ELEMENTARY_FILE_IDENTIFIER(SEL_ELEMENTARY_FILE_IDENTIFIER),
        .RD_MEM_REQ(RD_MEM_REQ), .RD_HOST_REQ(RD_HOST_REQ), .RD_ADDR(RD_ADDR),
        .RD_LEN(RD_LEN));
    typeb_reader_model typeb_reader_model_i (.REF_CLK(REF_CLK), .RX_VALID(RX_VALID),
        .RX_DATA(RX_DATA), .RX_END(RX_END), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
        .TX_LAST(TX_LAST), .TX_READY(TX_READY));

    // 125 MHz clock
    initial begin
        REF_CLK = 1'b0;
        forever #4 REF_CLK = ~REF_CLK;
    end

    // Read pulses last one cycle, so they are counted as they pass
    always @(posedge REF_CLK) begin
        if (RD_MEM_REQ === 1'b1) mem_n++;
        if (RD_HOST_REQ === 1'b1) host_n++;
    end

    task automatic ck(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Whole answer: length, body bytes, then CRC_B low and high
    task automatic ck_rsp(input logic [15:0] body, input int nb);
        logic [7:0]  g [16];
        logic [15:0] c;
        g[0] = (nb == 2) ? body[15:8] : body[7:0];
        g[1] = body[7:0];
        c = typeb_reader_model_i.crc_b(g, nb);
        ck(typeb_reader_model_i.rn, nb + 2);
        for (int i = 0; i < nb; i++) ck(typeb_reader_model_i.rsp[i], g[i]);
        ck(typeb_reader_model_i.rsp[nb], c[7:0]);
        ck(typeb_reader_model_i.rsp[nb+1], c[15:8]);
    endtask

    task automatic sel(input logic [7:0] cla, input logic [15:0] pp, input logic [7:0] lc,
        input logic [55:0] d, input int dn, input bit le, input logic [15:0] sw,
        input logic [2:0] k);
        int n;
        f[0] = cla;
        f[1] = 8'hA4;
        f[2] = pp[15:8];
        f[3] = pp[7:0];
        f[4] = lc;
        for (int i = 0; i < dn; i++) f[5 + i] = d[8 * (dn - 1 - i) +: 8];
        n = 5 + dn;
        if (le) begin
            f[n] = 8'h00;
            n++;
        end
        typeb_reader_model_i.xfer(f, n, 1'b0);
        ck_rsp(sw, 2);
        ck(SEL_KIND, k);
    endtask

    task automatic t_attr();
        f[0] = 8'h1D;
        for (int i = 1; i < 9; i++) f[i] = (i == 7) ? 8'h01 : 8'h00;
        typeb_reader_model_i.slow = 1'b1;
        typeb_reader_model_i.xfer(f, 9, 1'b0);
        ck_rsp(16'h0010, 1);
        typeb_reader_model_i.xfer(f, 9, 1'b1);
        ck(typeb_reader_model_i.rn, 0);
    endtask

    task automatic t_select();
        sel(8'h00, 16'h0400, 8'h07, 56'hD276_0000_8501_01, 7, 1, 16'h9000, 3'h2);
        sel(8'h00, 16'h0400, 8'h07, 56'hD276_0000_8501_02, 7, 1, 16'h6A82, 3'h2);
        sel(8'h00, 16'h0400, 8'h02, 56'hE103, 2, 0, 16'h6A82, 3'h2);
        sel(8'h00, 16'h000C, 8'h02, 56'hE103, 2, 0, 16'h9000, 3'h3);
        sel(8'h00, 16'h000C, 8'h02, 56'h0103, 2, 0, 16'h9000, 3'h4);
        sel(8'h00, 16'h020C, 8'h02, 56'hE103, 2, 0, 16'h9000, 3'h1);
        ck(SEL_ELEMENTARY_FILE_IDENTIFIER, 16'hE103);
        sel(8'h00, 16'h000C, 8'h02, 56'h5678, 2, 0, 16'h9000, 3'h1);
        ck(SEL_ELEMENTARY_FILE_IDENTIFIER, 16'h5678);
        sel(8'h00, 16'h0100, 8'h02, 56'hE103, 2, 0, 16'h6A82, 3'h1);
        sel(8'h00, 16'h000C, 8'h03, 56'hE1_0300, 3, 0, 16'h6A82, 3'h1);
        sel(8'h00, 16'h000C, 8'h02, 56'hE103, 2, 1, 16'h6A82, 3'h1);
        sel(8'h80, 16'h000C, 8'h02, 56'hE103, 2, 0, 16'h6A82, 3'h1);
    endtask

    task automatic t_read();
        typeb_reader_model_i.slow = 1'b0;
        f[0] = 8'h00;
        f[1] = 8'hB0;
        f[2] = 8'h12;
        f[3] = 8'h34;
        f[4] = 8'h10;
        typeb_reader_model_i.xfer(f, 5, 1'b0);
        ck(mem_n, 1);
        ck(host_n, 0);
        ck({RD_ADDR, RD_LEN}, 24'h12_3410);
        ck(typeb_reader_model_i.rn, 0);
        @(posedge REF_CLK) TUNNEL_MODE <= 1'b1;
        f[2] = 8'h56;
        typeb_reader_model_i.xfer(f, 5, 1'b0);
        ck(host_n, 1);
        ck(mem_n, 1);
        ck(RD_ADDR, 16'h5634);
    endtask

    task automatic t_halt();
        f[0] = 8'h50;
        for (int i = 0; i < 4; i++) f[1 + i] = PSEUDO_UNIQUE_ID[31 - 8 * i -: 8];
        f[4] = ~f[4];
        typeb_reader_model_i.xfer(f, 5, 1'b0);
        ck(typeb_reader_model_i.rn, 0);
        ck(HALTED, 1'b0);
        f[4] = ~f[4];
        typeb_reader_model_i.xfer(f, 5, 1'b0);
        ck_rsp(16'h0000, 1);
        ck(HALTED, 1'b1);
        f[0] = 8'h1D;
        typeb_reader_model_i.xfer(f, 9, 1'b0);
        ck(typeb_reader_model_i.rn, 0);
    endtask

    task automatic final_report();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main sequence: reset for five cycles, then the scenarios
    initial begin
        RST = 1'b1;
        TUNNEL_MODE = 1'b0;
        PSEUDO_UNIQUE_ID = 32'hA5C3_1E77;
        repeat (5) @(posedge REF_CLK);
        RST <= 1'b0;
        t_attr();
        t_select();
        t_read();
        t_halt();
        final_report();
    end

    // Watchdog; the whole run needs about 550 cycles
    initial begin
        repeat (6000) @(posedge REF_CLK);
        error_cnt++;
        final_report();
    end
endmodule // typeb_halt_select_cmd_tb_top
